// file: bcdtk_pkg.sv
package bcdtk_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CTRL_1 = 8'h00;
	localparam logic [7:0] OFS_CTRL_2 = 8'h01;
	localparam logic [7:0] OFS_SEC = 8'h03;
	localparam logic [7:0] OFS_MIN = 8'h04;
	localparam logic [7:0] OFS_HOUR = 8'h05;
	localparam logic [7:0] OFS_DAY = 8'h06;
	localparam logic [7:0] OFS_WDAY = 8'h07;
	localparam logic [7:0] OFS_MON = 8'h08;
	localparam logic [7:0] OFS_YEAR = 8'h09;
	localparam logic [7:0] OFS_SEC_MATCH = 8'h0a;
	// Field positions
	localparam int FLAG_BIT = 7;
	localparam int PM_BIT = 5;
	localparam int MODE12_BIT = 2;
	localparam int HIT_BIT = 4;
	// Writable field masks
	localparam logic [7:0] MASK_SEC = 8'h7f;
	localparam logic [7:0] MASK_MIN = 8'h7f;
	localparam logic [7:0] MASK_HOUR = 8'h3f;
	localparam logic [7:0] MASK_DAY = 8'h3f;
	localparam logic [7:0] MASK_WDAY = 8'h07;
	localparam logic [7:0] MASK_MON = 8'h1f;
	localparam logic [7:0] MASK_YEAR = 8'hff;
	// Counting limits
	localparam logic [7:0] LAST_SEC = 8'h59;
	localparam logic [7:0] LAST_MIN = 8'h59;
	localparam logic [7:0] LAST_HOUR_24 = 8'h23;
	localparam logic [4:0] HOUR_11 = 5'h11;
	localparam logic [4:0] HOUR_12 = 5'h12;
	localparam logic [4:0] HOUR_01 = 5'h01;
	localparam logic [2:0] LAST_WDAY = 3'h6;
	localparam logic [7:0] LAST_MON = 8'h12;
	localparam logic [7:0] LAST_YEAR = 8'h99;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] MON_APR = 8'h04;
	localparam logic [7:0] MON_JUN = 8'h06;
	localparam logic [7:0] MON_SEP = 8'h09;
	localparam logic [7:0] MON_NOV = 8'h11;
	localparam logic [7:0] DAYS_28 = 8'h28;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_31 = 8'h31;
	// Values after reset
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam logic [7:0] RST_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h00;
	localparam logic [7:0] RST_DAY = 8'h01;
	localparam logic [2:0] RST_WDAY = 3'h0;
	localparam logic [7:0] RST_MON = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [7:0] RST_SEC_MATCH = 8'h80;
endpackage : bcdtk_pkg

// file: bcdtk_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Seconds held as BCD, tens 0-5 in bits 6..4, units in 3..0.
// - Seconds bit 7 is the integrity-lost flag, one at start-up.
// - Minutes held as BCD tens 0-5 and units; bit 7 unused.
// - Hours: 12h uses bit 5 afternoon and bit 4 tens; 24h bits 5..4.
// - A control bit selects 12 or 24 hour counting.
// - Day of month BCD tens 0-3 in bits 5..4; bits 7..6 unused.
// - Year divisible by four, including zero, gives February 29 days.
// - Weekday is 0 to 6 in bits 2..0; upper bits unused.
// - Weekday counts 0 up to 6 then wraps to 0.
// - Month BCD 1 to 12, tens in bit 4; bits 7..5 unused.
// - Year held as two BCD digits, 00 to 99.
// - A 1 Hz tick advances seconds and carries through the calendar.
// - Time counters freeze while a host access is in progress.
// - One tick during an access is held and applied afterwards.
// - Enabled, valid second target is compared with the next seconds value.
// - Second target: bit 7 disables, default one; BCD target below.
// - Match hit flag sets on advancing into a match, held until cleared.
// - Internal reset sets the integrity flag; host clears with zero.
// - Reset selects 24-hour counting.
module bcdtk_core
	import bcdtk_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic tick_1hz,
	input wire logic acc_active,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic match_hit_flag
);

	logic tick_s1_ff;
	logic tick_s2_ff;
	logic tick_s3_ff;
	logic tick_edge;
	logic step;
	logic nxt_pend;
	logic pend_ff;
	logic [7:0] sec_ff;
	logic [7:0] min_ff;
	logic [7:0] hour_ff;
	logic [7:0] day_ff;
	logic [2:0] wday_ff;
	logic [7:0] mon_ff;
	logic [7:0] year_ff;
	logic [7:0] nxt_sec;
	logic [7:0] nxt_min;
	logic [7:0] nxt_hour;
	logic [7:0] nxt_day;
	logic [2:0] nxt_wday;
	logic [7:0] nxt_mon;
	logic [7:0] nxt_year;
	logic [7:0] sec_match_ff;
	logic [7:0] last_day;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;
	logic clock_integrity_lost_flag_ff;
	logic mode12_ff;
	logic hit_ff;
	logic c_min;
	logic c_hour;
	logic c_day;
	logic c_mon;
	logic c_year;
	logic leap;
	logic target_valid;
	logic sec_match_disable;
	logic sec_hit;
	logic wr_ctrl_1;
	logic wr_ctrl_2;
	logic wr_sec;
	logic wr_min;
	logic wr_hour;
	logic wr_day;
	logic wr_wday;
	logic wr_mon;
	logic wr_year;
	logic wr_sec_match;
	logic hour_is_11;
	logic [4:0] hour_12_next;
	logic [3:0] year_tens;
	logic [3:0] year_units;

	function automatic logic [7:0] bcd_next(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_next

	// One strobe per register keeps each update block to its own concern
	assign wr_ctrl_1 = wr_en && (addr == OFS_CTRL_1);
	assign wr_ctrl_2 = wr_en && (addr == OFS_CTRL_2);
	assign wr_sec = wr_en && (addr == OFS_SEC);
	assign wr_min = wr_en && (addr == OFS_MIN);
	assign wr_hour = wr_en && (addr == OFS_HOUR);
	assign wr_day = wr_en && (addr == OFS_DAY);
	assign wr_wday = wr_en && (addr == OFS_WDAY);
	assign wr_mon = wr_en && (addr == OFS_MON);
	assign wr_year = wr_en && (addr == OFS_YEAR);
	assign wr_sec_match = wr_en && (addr == OFS_SEC_MATCH);

	// Tick comes from the oscillator domain, so synchronise first
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_s1_ff <= 1'b0;
			tick_s2_ff <= 1'b0;
			tick_s3_ff <= 1'b0;
		end else begin
			tick_s1_ff <= tick_1hz;
			tick_s2_ff <= tick_s1_ff;
			tick_s3_ff <= tick_s2_ff;
		end
	end

	assign tick_edge = tick_s2_ff & ~tick_s3_ff;

	// Further ticks during one access are dropped
	assign step = ~acc_active & (pend_ff | tick_edge);
	assign nxt_pend = acc_active ? (pend_ff | tick_edge)
		: (pend_ff & tick_edge);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			pend_ff <= 1'b0;
		else
			pend_ff <= nxt_pend;
	end

	assign year_tens = year_ff[7:4];
	assign year_units = year_ff[3:0];
	// Leap test on BCD: (2*tens + units) mod 4
	assign leap = (2'(year_units[1:0] + {year_tens[0], 1'b0}) == 2'h0);

	always_comb begin
		if (mon_ff == MON_FEB)
			last_day = leap ? DAYS_29 : DAYS_28;
		else if (mon_ff == MON_APR || mon_ff == MON_JUN ||
			mon_ff == MON_SEP || mon_ff == MON_NOV)
			last_day = DAYS_30;
		else
			last_day = DAYS_31;
	end

	always_comb begin
		nxt_sec = sec_ff;
		c_min = 1'b0;
		if (step) begin
			c_min = (sec_ff == LAST_SEC);
			nxt_sec = c_min ? 8'h00 : bcd_next(sec_ff);
		end
	end

	always_comb begin
		nxt_min = min_ff;
		c_hour = 1'b0;
		if (c_min) begin
			c_hour = (min_ff == LAST_MIN);
			nxt_min = c_hour ? 8'h00 : bcd_next(min_ff);
		end
	end

	assign hour_is_11 = (hour_ff[4:0] == HOUR_11);

	always_comb begin
		if (hour_is_11)
			hour_12_next = HOUR_12;
		else if (hour_ff[4:0] == HOUR_12)
			hour_12_next = HOUR_01;
		else
			hour_12_next = 5'(bcd_next({3'b000, hour_ff[4:0]}));
	end

	always_comb begin
		nxt_hour = hour_ff;
		c_day = 1'b0;
		if (c_hour) begin
			if (mode12_ff) begin
				// Afternoon 11 to 12 is the only 12-hour step into a new day
				c_day = hour_is_11 && hour_ff[PM_BIT];
				nxt_hour = {2'b00, hour_ff[PM_BIT] ^ hour_is_11,
					hour_12_next};
			end else begin
				c_day = (hour_ff == LAST_HOUR_24);
				nxt_hour = c_day ? 8'h00 : bcd_next(hour_ff);
			end
		end
	end

	always_comb begin
		nxt_wday = wday_ff;
		if (c_day)
			nxt_wday = (wday_ff == LAST_WDAY) ? 3'h0 :
				3'(wday_ff + 3'h1);
	end

	always_comb begin
		nxt_day = day_ff;
		c_mon = 1'b0;
		if (c_day) begin
			c_mon = (day_ff == last_day);
			nxt_day = c_mon ? 8'h01 : bcd_next(day_ff);
		end
	end

	always_comb begin
		nxt_mon = mon_ff;
		c_year = 1'b0;
		if (c_mon) begin
			c_year = (mon_ff == LAST_MON);
			nxt_mon = c_year ? 8'h01 : bcd_next(mon_ff);
		end
	end

	always_comb begin
		nxt_year = year_ff;
		if (c_year)
			nxt_year = (year_ff == LAST_YEAR) ? 8'h00 :
				bcd_next(year_ff);
	end

	// Host writes win over counting; the host also writes outside an access
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sec_ff <= RST_SEC;
		else if (wr_sec)
			sec_ff <= wdata & MASK_SEC;
		else
			sec_ff <= nxt_sec;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			min_ff <= RST_MIN;
		else if (wr_min)
			min_ff <= wdata & MASK_MIN;
		else
			min_ff <= nxt_min;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			hour_ff <= RST_HOUR;
		else if (wr_hour)
			hour_ff <= wdata & MASK_HOUR;
		else
			hour_ff <= nxt_hour;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			day_ff <= RST_DAY;
		else if (wr_day)
			day_ff <= wdata & MASK_DAY;
		else
			day_ff <= nxt_day;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			wday_ff <= RST_WDAY;
		else if (wr_wday)
			wday_ff <= wdata[2:0];
		else
			wday_ff <= nxt_wday;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			mon_ff <= RST_MON;
		else if (wr_mon)
			mon_ff <= wdata & MASK_MON;
		else
			mon_ff <= nxt_mon;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			year_ff <= RST_YEAR;
		else if (wr_year)
			year_ff <= wdata & MASK_YEAR;
		else
			year_ff <= nxt_year;
	end

	// Only a reset sets it, so a write can clear but never set
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			clock_integrity_lost_flag_ff <= 1'b1;
		else if (wr_sec)
			clock_integrity_lost_flag_ff <= clock_integrity_lost_flag_ff &
				wdata[FLAG_BIT];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			mode12_ff <= 1'b0;
		else if (wr_ctrl_1)
			mode12_ff <= wdata[MODE12_BIT];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sec_match_ff <= RST_SEC_MATCH;
		else if (wr_sec_match)
			sec_match_ff <= wdata;
	end

	assign sec_match_disable = sec_match_ff[FLAG_BIT];
	// Target outside 00..59 never matches
	assign target_valid = (sec_match_ff[6:4] <= 3'h5) &&
		(sec_match_ff[3:0] <= 4'h9);
	// A write landing with the advance replaces it, so no hit then
	assign sec_hit = step && !wr_sec && !sec_match_disable &&
		target_valid && (nxt_sec[6:0] == sec_match_ff[6:0]);

	// Set only on advancing into a match; set wins over a clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			hit_ff <= 1'b0;
		else if (sec_hit)
			hit_ff <= 1'b1;
		else if (wr_ctrl_2 && !wdata[HIT_BIT])
			hit_ff <= 1'b0;
	end

	always_comb begin
		case (addr)
			OFS_CTRL_1: nxt_rdata = 8'(mode12_ff) << MODE12_BIT;
			OFS_CTRL_2: nxt_rdata = 8'(hit_ff) << HIT_BIT;
			OFS_SEC: nxt_rdata = {clock_integrity_lost_flag_ff, sec_ff[6:0]};
			OFS_MIN: nxt_rdata = min_ff;
			OFS_HOUR: nxt_rdata = hour_ff;
			OFS_DAY: nxt_rdata = day_ff;
			OFS_WDAY: nxt_rdata = {5'h00, wday_ff};
			OFS_MON: nxt_rdata = mon_ff;
			OFS_YEAR: nxt_rdata = year_ff;
			OFS_SEC_MATCH: nxt_rdata = sec_match_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign rdata = rdata_ff;
	assign match_hit_flag = hit_ff;

endmodule : bcdtk_core

// file: bcdtk_core_checker.sv
`timescale 1ns/100ps
module bcdtk_core_checker
	import bcdtk_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic tick_1hz,
	input wire logic acc_active,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic match_hit_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	chk_sec_bcd:
	assert property (addr == OFS_SEC |=> rdata[6:4] <= 3'h5 &&
		rdata[3:0] <= 4'h9) else $error("seconds digit range");
	chk_min_top:
	assert property (addr == OFS_MIN |=> !rdata[7] && rdata[6:4] <= 3'h5)
		else $error("minutes digit range");
	chk_hour_top:
	assert property (addr == OFS_HOUR |=> rdata[7:6] == 2'h0 &&
		rdata[3:0] <= 4'h9) else $error("hours digit range");
	chk_day_top:
	assert property (addr == OFS_DAY |=> rdata[7:6] == 2'h0)
		else $error("day unused bits");
	chk_wday_range:
	assert property (addr == OFS_WDAY |=> rdata <= 8'h06)
		else $error("weekday range");
	chk_mon_top:
	assert property (addr == OFS_MON |=> rdata[7:5] == 3'h0)
		else $error("month unused bits");
	chk_unmapped_zero:
	assert property (addr > OFS_SEC_MATCH |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_hit_unfrozen:
	assert property ($rose(match_hit_flag) |-> !$past(acc_active))
		else $error("hit flag rose while frozen");
	chk_hit_clear:
	assert property (acc_active && wr_en && addr == OFS_CTRL_2 &&
		!wdata[HIT_BIT] |=> !match_hit_flag) else $error("hit not cleared");
endmodule : bcdtk_core_checker
bind bcdtk_core bcdtk_core_checker u_chk (.core_clk(core_clk),
	.reset_n(reset_n), .tick_1hz(tick_1hz), .acc_active(acc_active),
	.wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata),
	.match_hit_flag(match_hit_flag));

// file: bcdtk_host.sv
`timescale 1ns/100ps
module bcdtk_host
	import bcdtk_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] rdata,
	output logic acc_active,
	output logic wr_en,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial begin
		acc_active = 1'b0;
		wr_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// Bursts stay far below one second, so one held tick suffices
	task hold(input logic on);
		@(posedge core_clk);
		acc_active <= on;
	endtask : hold
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
		wdata <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		repeat (2) @(posedge core_clk);
		d = rdata;
	endtask : rd
endmodule : bcdtk_host

// file: bcdtk_core_tb.sv
`timescale 1ns/100ps
module bcdtk_core_tb;
	import bcdtk_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic tick_1hz = 1'b0;
	logic acc_active, wr_en, match_hit_flag;
	logic [7:0] addr, wdata, rdata, v, r;
	logic [31:0] seed = 32'haa822076;
	int failures;
	int compares;
	logic [119:0] cal [8] = '{120'h00_59592328060201_00000001000301,
		120'h00_59592328020204_00000029030204,
		120'h00_59592329000200_00000001010300,
		120'h00_59592331031299_00000001040100,
		120'h00_59592330010410_00000001020510,
		120'h04_59591115000101_00003215000101,
		120'h04_59591215000101_00000115000101,
		120'h04_59593115000101_00001216010101};
	always #50 core_clk = ~core_clk;
	bcdtk_core u_dut (.core_clk(core_clk), .reset_n(reset_n),
		.tick_1hz(tick_1hz), .acc_active(acc_active), .wr_en(wr_en),
		.addr(addr), .wdata(wdata), .rdata(rdata),
		.match_hit_flag(match_hit_flag));
	bcdtk_host u_host (.core_clk(core_clk), .rdata(rdata),
		.acc_active(acc_active), .wr_en(wr_en), .addr(addr), .wdata(wdata));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function logic [7:0] bcd_inc(input logic [7:0] s);
		return (s[3:0] == 4'h9) ? {s[7:4] + 4'h1, 4'h0} : s + 8'h01;
	endfunction : bcd_inc
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, v);
		chk(n, e, v);
	endtask : rdc
	task tick; // High long enough to clear the synchroniser
		@(posedge core_clk);
		tick_1hz <= 1'b1;
		repeat (3) @(posedge core_clk);
		tick_1hz <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : tick
	task end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		#1_000_000;
		failures++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rdc("rst", OFS_SEC + 8'(i), 8'(56'h80000001000100 >> (48 - 8 * i)));
		rdc("ctrl", OFS_CTRL_1, 8'h00);
		rdc("tgt", OFS_SEC_MATCH, 8'h80);
		foreach (cal[k]) begin
			u_host.wr(OFS_CTRL_1, cal[k][119:112]);
			u_host.hold(1'b1);
			for (int i = 0; i < 7; i++)
				u_host.wr(OFS_SEC + 8'(i), cal[k][111 - 8 * i -: 8]);
			u_host.hold(1'b0);
			tick;
			for (int i = 0; i < 7; i++)
				rdc("cal", OFS_SEC + 8'(i), cal[k][55 - 8 * i -: 8]);
		end
		u_host.wr(OFS_SEC, 8'h80);
		rdc("flag", OFS_SEC, 8'h00);
		u_host.wr(8'h20, 8'hff);
		rdc("unmapped", 8'h20, 8'h00);
		repeat (6) begin
			seed = lfsr(seed);
			r = {1'b0, 3'(seed[2:0] % 3'd5), 4'(seed[7:4] % 4'd10)};
			u_host.wr(OFS_SEC, r);
			tick;
			rdc("sec", OFS_SEC, bcd_inc(r));
		end
		u_host.wr(OFS_SEC, 8'h10);
		u_host.hold(1'b1);
		tick;
		tick;
		rdc("frozen", OFS_SEC, 8'h10);
		u_host.hold(1'b0);
		repeat (2) @(posedge core_clk);
		rdc("held", OFS_SEC, 8'h11);
		u_host.wr(OFS_SEC_MATCH, 8'h12);
		tick;
		chk("hit", 8'h01, {7'h00, match_hit_flag});
		u_host.hold(1'b1);
		u_host.wr(OFS_CTRL_2, 8'h00);
		u_host.hold(1'b0);
		chk("clr", 8'h00, {7'h00, match_hit_flag});
		u_host.wr(OFS_SEC_MATCH, 8'h93);
		tick;
		chk("off", 8'h00, {7'h00, match_hit_flag});
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		rdc("rerst", OFS_SEC, 8'h80);
		rdc("remode", OFS_CTRL_1, 8'h00);
		end_of_test;
	end
endmodule : bcdtk_core_tb
